//--- logic/irq_mode_regs.sv
// Status, mask and framer mode register bank behind a 16-bit host port.
// Assumes host strobes and event pulses are synchronous to ref_clk; the
// cell start strobe and clock-failure levels come from other domains.
`timescale 1ns/1ps
module irq_mode_regs
	import irq_mode_pkg::*;
#(
	parameter int PORTS = 8                                    // Number of line ports.
)(
	input  wire logic              ref_clk,                  // System clock, 10 MHz.
	input  wire logic              rst,                      // Asynchronous reset, high.
	input  wire logic              link_clk,                 // Cell bus clock.
	input  wire host_req_t         host_req,                 // Host read or write strobe.
	output      logic [15:0]       host_rdata,               // Registered read data.
	input  wire logic              cell_start_strobe,        // Cell start on the link.
	input  wire logic              cell_start_check_en,      // Check enabled for this role.
	input  wire err_events_t       err_event,                // Other one-cycle error events.
	input  wire logic              queue_has_entries,        // Interrupt queue not empty.
	input  wire logic              queue_read,               // Queue head read by host.
	input  wire logic              filter_queue_full,        // Filter queue full event.
	input  wire logic              filter_queue_nonempty,    // Filter queue nonempty event.
	input  wire logic [PORTS-1:0]  timestamp_overflow,       // Per-port overflow events.
	input  wire logic [PORTS-1:0]  first_group_timer_expired,  // Timer group one events.
	input  wire logic [PORTS-1:0]  second_group_timer_expired, // Timer group two events.
	input  wire logic [PORTS-1:0]  delin_loss_start,         // Loss of delineation begins.
	input  wire logic [PORTS-1:0]  delin_loss_end,           // Loss of delineation ends.
	input  wire logic [PORTS-1:0]  cell_port_cfg,            // One selects cell port.
	input  wire logic [2*PORTS-1:0] port_delineation_state,  // Two bits per port.
	input  wire logic [PORTS-1:0]  rx_clock_fail_raw,        // Live failure, async.
	input  wire logic              bus_style_pin,            // Host bus protocol strap.
	input  wire logic              canceller_pin_state,      // Canceller strap.
	input  wire logic              line_standard_pin_state,  // Line standard strap.
	input  wire logic [3:0]        tx_buffer_level,          // Transmit cell buffer level.
	output      logic              tx_buffer_below_level,    // Level under threshold.
	output      logic              irq,                      // Unmasked status present.
	output      logic              second_timer_group_enable, // Timer group two runs.
	output      mode_ctl_t         mode_ctl                  // Framer mode controls.
);

	////////////////////////////////////////////////////////////////////////////////
	// Link domain: cell start timing check.

	logic [5:0] soc_gap;                                       // Clocks since last start.
	logic       soc_seen;                                      // A start has occurred.
	logic       soc_err_tgl;                                   // Toggles on each error.
	wire  logic soc_double = cell_start_strobe && soc_seen && (soc_gap < CELL_CLKS);
	wire  logic soc_late   = !cell_start_strobe && soc_seen && (soc_gap == CELL_CLKS);

	// Counts link clocks between starts; a strobe inside a cell or a missing one is an error.
	always_ff @(posedge link_clk or posedge rst) begin
		if (rst) begin
			soc_gap     <= 6'h0;
			soc_seen    <= 1'b0;
			soc_err_tgl <= 1'b0;
		end else begin
			soc_gap     <= cell_start_strobe ? 6'h1 : (soc_gap == CELL_CLKS ? soc_gap : soc_gap + 6'h1);
			soc_seen    <= soc_seen | cell_start_strobe;
			if (cell_start_check_en && (soc_double || soc_late)) begin
				soc_err_tgl <= ~soc_err_tgl;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Crossings into ref_clk.

	logic [2:0]       soc_sync;                                // Toggle synchroniser and edge.
	logic [PORTS-1:0] fail_s1;                                 // First stage, clock failure.
	logic [PORTS-1:0] fail_s2;                                 // Second stage, clock failure.

	// Two flops for each level; the toggle gets a third for edge detection.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			soc_sync <= 3'h0;
			fail_s1  <= '0;
			fail_s2  <= '0;
		end else begin
			soc_sync <= {soc_sync[1:0], soc_err_tgl};
			fail_s1  <= rx_clock_fail_raw;
			fail_s2  <= fail_s1;
		end
	end

	wire logic soc_err_pulse = soc_sync[2] ^ soc_sync[1];     // One pulse per error.

	////////////////////////////////////////////////////////////////////////////////
	// Register storage and access decode.

	logic [15:0]      mask_reg;                                // Interrupt mask.
	logic             timer_en;                                // Second timer group enable.
	logic [15:0]      mode_reg;                                // Operating mode.
	logic [15:0]      txclk_reg;                               // Transmit clock sources.
	logic [6:0]       err_flags;                               // Latched errors.
	logic             queue_flag;                              // Queue summary.
	logic [1:0]       filt_flags;                              // Filter flags.
	logic [PORTS-1:0] ts_flags;                                // Timestamp overflow flags.
	logic [PORTS-1:0] tim1_flags;                              // Timer group one flags.
	logic [PORTS-1:0] tim2_flags;                              // Timer group two flags.
	logic [PORTS-1:0] dl_start;                                // Delineation loss start.
	logic [PORTS-1:0] dl_end;                                  // Delineation loss end.
	logic             bus_style;                               // Strap captured after reset.
	logic             canc_strap;                              // Canceller strap captured.
	logic             line_strap;                              // Line strap captured.

	wire logic rd = host_req.rd;
	wire logic wr = host_req.wr;
	wire logic [ADDR_W-1:0] a = host_req.addr;
	wire logic rd_stat1 = rd && (a == ADDR_STAT1);
	wire logic rd_filt  = rd && (a == ADDR_EXT_FILT);
	wire logic rd_ts    = rd && (a == ADDR_EXT_TS);
	wire logic rd_tim1  = rd && (a == ADDR_EXT_TIM1);
	wire logic rd_delin = rd && (a == ADDR_EXT_DELIN);
	wire logic rd_tim2  = rd && (a == ADDR_STAT2);

	// Not-applicable per-port events are gated by each port's cell-port bit.
	wire logic [PORTS-1:0] ts_ev  = timestamp_overflow & ~cell_port_cfg;
	wire logic [PORTS-1:0] dls_ev = delin_loss_start & cell_port_cfg;
	wire logic [PORTS-1:0] dle_ev = delin_loss_end & cell_port_cfg;
	wire logic [PORTS-1:0] t2_ev  = second_group_timer_expired & {PORTS{timer_en}};

	// Hardware set beats the clearing read.
	function automatic logic [PORTS-1:0] sticky(input logic [PORTS-1:0] cur,
	                                            input logic [PORTS-1:0] ev,
	                                            input logic clr);
		sticky = (clr ? '0 : cur) | ev;
	endfunction

	wire err_events_t all_err = '{
		cell_start_error:       err_event.cell_start_error | soc_err_pulse,
		cell_bus_parity_error:  err_event.cell_bus_parity_error,
		memory_parity_error:    err_event.memory_parity_error,
		recovery_parity_error:  err_event.recovery_parity_error,
		output_queue_overflow:  err_event.output_queue_overflow,
		error_queue_overflow:   err_event.error_queue_overflow,
		emergency_state_change: err_event.emergency_state_change
	};

	// Summary bits follow their underlying registers directly.
	wire logic [5:0] summary = {queue_flag, |dl_end | |dl_start, |tim1_flags, |ts_flags,
	                            |filt_flags, |tim2_flags};
	wire logic [15:0] stat1_word = {summary, 3'h0, err_flags};
	wire logic [15:0] rev_word = {7'h0, bus_style, canc_strap, line_strap, REVISION};

	logic [15:0] delin_word;                                   // Per-port state, zero if n/a.
	always_comb begin
		delin_word = 16'h0000;
		for (int p = 0; p < PORTS; p++) begin
			delin_word[2*p +: 2] = cell_port_cfg[p] ? port_delineation_state[2*p +: 2] : DEL_HUNT;
		end
	end

	wire logic [15:0] next_rdata =
		(a == ADDR_MASK)      ? mask_reg :
		(a == ADDR_TIMER_EN)  ? {15'h0, timer_en} :
		(a == ADDR_DELIN)     ? delin_word :
		(a == ADDR_REV)       ? rev_word :
		(a == ADDR_CLKMON)    ? {8'h0, fail_s2} :
		(a == ADDR_STAT1)     ? stat1_word :
		(a == ADDR_EXT_FILT)  ? {14'h0, filt_flags} :
		(a == ADDR_EXT_TS)    ? {8'h0, ts_flags} :
		(a == ADDR_EXT_TIM1)  ? {8'h0, tim1_flags} :
		(a == ADDR_EXT_DELIN) ? {dl_end, dl_start} :
		(a == ADDR_STAT2)     ? {8'h0, tim2_flags} :
		(a == ADDR_MODE)      ? mode_reg :
		(a == ADDR_TXCLK)     ? txclk_reg : ZERO16;

	////////////////////////////////////////////////////////////////////////////////
	// Writable registers.

	// Software writes land in the addressed register; reads have no effect here.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			mask_reg  <= MASK_RESET;
			timer_en  <= 1'b0;
			mode_reg  <= MODE_RESET;
			txclk_reg <= ZERO16;
		end else if (wr) begin
			if (a == ADDR_MASK) begin
				mask_reg <= host_req.wdata;
			end else if (a == ADDR_TIMER_EN) begin
				timer_en <= host_req.wdata[0];
			end else if (a == ADDR_MODE) begin
				mode_reg <= host_req.wdata;
			end else if (a == ADDR_TXCLK) begin
				txclk_reg <= host_req.wdata;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Clear-on-read status flags.

	// Each flag sets on its event and clears when its own register is read; the queue flag clears on queue_read instead.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			err_flags  <= 7'h0;
			queue_flag <= 1'b0;
			filt_flags <= 2'h0;
			ts_flags   <= '0;
			tim1_flags <= '0;
			tim2_flags <= '0;
			dl_start   <= '0;
			dl_end     <= '0;
		end else begin
			err_flags  <= (rd_stat1 ? 7'h0 : err_flags) | all_err;
			queue_flag <= (queue_read ? 1'b0 : queue_flag) | queue_has_entries;
			filt_flags <= (rd_filt ? 2'h0 : filt_flags) |
			              {filter_queue_nonempty, filter_queue_full};
			ts_flags   <= sticky(ts_flags, ts_ev, rd_ts);
			tim1_flags <= sticky(tim1_flags, first_group_timer_expired, rd_tim1);
			tim2_flags <= sticky(tim2_flags, t2_ev, rd_tim2);
			dl_start   <= sticky(dl_start, dls_ev, rd_delin);
			dl_end     <= sticky(dl_end, dle_ev, rd_delin);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Straps, read data and framer-facing outputs.

	logic [2:0] strap_s1;                                      // First stage of the straps.

	// Straps pass two flops like any other pin, so a pin that settles late cannot
	// leave a half-resolved level in the revision word.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			strap_s1   <= 3'h0;
			bus_style  <= 1'b0;
			canc_strap <= 1'b0;
			line_strap <= 1'b0;
		end else begin
			strap_s1   <= {bus_style_pin, canceller_pin_state, line_standard_pin_state};
			bus_style  <= strap_s1[2];
			canc_strap <= strap_s1[1];
			line_strap <= strap_s1[0];
		end
	end

	wire logic [3:0] thr = mode_reg[MD_THR_LO +: 4];
	wire framer_mode_t om = framer_mode_t'(mode_reg[MD_OM_LO +: 2]);
	wire logic is_sync = (om == sync_8m_mode) || (om == sync_2m_mode);
	wire logic is_gen  = (om == generic_framer_mode);

	// In 2 MHz sync mode the receive bit sets sampling; transmit uses the other edge.
	wire mode_ctl_t next_ctl = '{
		mode:             om,
		own_sync_pulse:   is_sync & mode_reg[MD_SYNC_SEL],
		ts_from_recovery: mode_reg[MD_TS_GEN],
		tx_clk_pins_out:  mode_reg[MD_TS_EVAL],
		tx_pulse_high:    is_gen & mode_reg[MD_TFPP],
		rx_pulse_high:    (is_gen | is_sync) & mode_reg[MD_RFPP],
		tx_drive_rise:    (om == sync_2m_mode) ? ~mode_reg[MD_RX_RISE]
		                                       : mode_reg[MD_TX_RISE],
		rx_sample_rise:   mode_reg[MD_RX_RISE],
		doubler_on:       ~mode_reg[MD_BYPASS],
		tx_clock_source:  (is_sync ? ZERO16 : txclk_reg)
	};

	// Registered outputs and host read data.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			host_rdata                <= ZERO16;
			tx_buffer_below_level     <= 1'b0;
			irq                       <= 1'b0;
			second_timer_group_enable <= 1'b0;
			mode_ctl                  <= '0;
		end else begin
			host_rdata                <= rd ? next_rdata : host_rdata;
			tx_buffer_below_level     <= tx_buffer_level < thr;
			irq                       <= |(stat1_word & ~mask_reg);
			second_timer_group_enable <= timer_en;
			mode_ctl                  <= next_ctl;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks.

	a_mask_reset_irq: assert property (@(posedge ref_clk) disable iff (rst)
		(mask_reg == 16'hffff) |=> !irq) else $error("irq raised with all masked");

	a_err_clear_read: assert property (@(posedge ref_clk) disable iff (rst)
		(rd_stat1 && all_err == '0) |=> (err_flags == 7'h0)) else $error("errors kept after read");

	a_set_wins_clear: assert property (@(posedge ref_clk) disable iff (rst)
		(rd_tim1 && first_group_timer_expired[0]) |=> tim1_flags[0]) else $error("event lost");

	a_timer_gated: assert property (@(posedge ref_clk) disable iff (rst)
		(!timer_en && !$past(tim2_flags[0]) && rd_tim2) |=> !tim2_flags[0]) else $error("timer set while off");

	a_clock_fail_live: assert property (@(posedge ref_clk) disable iff (rst)
		(rx_clock_fail_raw[0] == 1'b0)[*3] |-> !fail_s2[0]) else $error("failure kept");

	a_summary_stat: assert property (@(posedge ref_clk) disable iff (rst)
		(|filt_flags) |-> stat1_word[11]) else $error("summary missing");

	a_buffer_level: assert property (@(posedge ref_clk) disable iff (rst)
		(tx_buffer_level < thr) |=> tx_buffer_below_level) else $error("level output wrong");

	a_doubler_bypass: assert property (@(posedge ref_clk) disable iff (rst)
		mode_reg[MD_BYPASS] |=> !mode_ctl.doubler_on) else $error("doubler not bypassed");

endmodule

//--- common/irq_mode_pkg.sv
// Constants, field layouts and carrier types for the status and mode register bank.
// Assumes a 16-bit parallel host port with word addresses and one-cycle strobes.
//
// Behaviour
// - Mask bit one suppresses matching status interrupt.
// - Two-bit delineation state per port, eight ports.
// - Bit 8 shows host bus protocol style.
// - Strap pins and six-bit revision readable.
// - Clock failure bit follows live detection only.
// - Queue and five summary flags in status.
// - Cell start strobe late or double is error.
// - Error bits six to zero clear on read.
// - Summary bits clear via underlying register read.
// - Latched errors: parity, overflows, emergency change.
// - Filter queue full and nonempty, clear on read.
// - Per-port timestamp overflow flags, clear on read.
// - First timer group expiry flags, clear on read.
// - Delineation loss end and start flags.
// - Second timer group flags; runs only enabled.
// - Sync select picks common or own pulse.
// - Timestamp source and transmit clock pin direction.
// - Buffer level below threshold drives output.
// - Frame pulse polarity bits per mode.
// - Edge bits choose data drive and sample edges.
// - Two-bit field selects four framer modes.
// - Bypass bit disables reference clock doubling.
// - Per-port transmit clock source select, forced to zero in sync modes.
// - Cell-port bit qualifies not applicable fields.
package irq_mode_pkg;

	localparam int ADDR_W = 6;                                 // Word address width.
	localparam logic [5:0] ADDR_MASK      = 6'h13;             // Interrupt mask.
	localparam logic [5:0] ADDR_TIMER_EN  = 6'h14;             // Second timer group enable.
	localparam logic [5:0] ADDR_DELIN     = 6'h15;             // Delineation state.
	localparam logic [5:0] ADDR_REV       = 6'h16;             // Revision and straps.
	localparam logic [5:0] ADDR_CLKMON    = 6'h17;             // Line clock monitor.
	localparam logic [5:0] ADDR_STAT1     = 6'h18;             // Primary status.
	localparam logic [5:0] ADDR_EXT_FILT  = 6'h19;             // Filter status.
	localparam logic [5:0] ADDR_EXT_TS    = 6'h1a;             // Timestamp status.
	localparam logic [5:0] ADDR_EXT_TIM1  = 6'h1b;             // First timer status.
	localparam logic [5:0] ADDR_EXT_DELIN = 6'h1c;             // Delineation status.
	localparam logic [5:0] ADDR_STAT2     = 6'h1d;             // Second timer status.
	localparam logic [5:0] ADDR_MODE      = 6'h1e;             // Operating mode.
	localparam logic [5:0] ADDR_TXCLK     = 6'h1f;             // Transmit clock source.

	localparam logic [15:0] MASK_RESET = 16'hffff;             // Mask reset value.
	localparam logic [15:0] MODE_RESET = 16'h1100;             // Mode reset value.
	localparam logic [15:0] ZERO16     = 16'h0000;             // Generic zero reset.
	localparam logic [5:0]  REVISION   = 6'h2a;                // Arbitrary revision value.

	// Bit positions inside the primary status and revision words.
	localparam int ST_QUEUE   = 15;                            // Queue has entries.
	localparam int ST_SUM_LO  = 10;                            // Lowest summary bit.
	localparam int REV_BUS    = 8;                             // Bus style bit.
	localparam int REV_CANC   = 7;                             // Canceller strap bit.
	localparam int REV_LINE   = 6;                             // Line standard strap bit.

	// Bit positions inside the operating mode word.
	localparam int MD_SYNC_SEL = 13;                           // Per-port sync pulse select.
	localparam int MD_TS_GEN   = 12;                           // Timestamp generation.
	localparam int MD_TS_EVAL  = 11;                           // Timestamp evaluation.
	localparam int MD_THR_LO   = 7;                            // Threshold low bit.
	localparam int MD_TFPP     = 6;                            // Transmit pulse polarity.
	localparam int MD_RFPP     = 5;                            // Receive pulse polarity.
	localparam int MD_TX_RISE  = 4;                            // Transmit rising edge.
	localparam int MD_RX_RISE  = 3;                            // Receive rising edge.
	localparam int MD_OM_LO    = 1;                            // Mode field low bit.
	localparam int MD_BYPASS   = 0;                            // Doubler bypass.

	// Framer operating modes.
	typedef enum logic [1:0] {
		high_rate_framer_mode = 2'h0,
		generic_framer_mode   = 2'h1,
		sync_8m_mode          = 2'h2,
		sync_2m_mode          = 2'h3
	} framer_mode_t;

	// Delineation codes.
	localparam logic [1:0] DEL_HUNT = 2'h0;
	localparam logic [1:0] DEL_PRE  = 2'h1;
	localparam logic [1:0] DEL_SYNC = 2'h2;

	// Transmit clock source codes.
	localparam logic [1:0] TXC_PIN  = 2'h0;
	localparam logic [1:0] TXC_RX   = 2'h1;
	localparam logic [1:0] TXC_REF  = 2'h2;
	localparam logic [1:0] TXC_NONE = 2'h3;

	// Start-of-cell check: strobe spacing in link clocks for one cell.
	localparam logic [5:0] CELL_CLKS = 6'h35;                  // Fifty-three octets per cell.

	// Latched error event bundle, bits six down to zero.
	typedef struct packed {
		logic cell_start_error;
		logic cell_bus_parity_error;
		logic memory_parity_error;
		logic recovery_parity_error;
		logic output_queue_overflow;
		logic error_queue_overflow;
		logic emergency_state_change;
	} err_events_t;

	// Host port request.
	typedef struct packed {
		logic              rd;
		logic              wr;
		logic [ADDR_W-1:0] addr;
		logic [15:0]       wdata;
	} host_req_t;

	// Framer-facing mode controls.
	typedef struct packed {
		framer_mode_t mode;
		logic         own_sync_pulse;
		logic         ts_from_recovery;
		logic         tx_clk_pins_out;
		logic         tx_pulse_high;
		logic         rx_pulse_high;
		logic         tx_drive_rise;
		logic         rx_sample_rise;
		logic         doubler_on;
		logic [15:0]  tx_clock_source;
	} mode_ctl_t;

endpackage

//--- bench/irq_host_model.sv
// Host processor model for the status and mode register bank.
// Assumes the bank takes one-cycle strobes on the rising ref_clk edge.
`timescale 1ns/1ps
module irq_host_model
	import irq_mode_pkg::*;
(
	input  wire logic        ref_clk, // System clock.
	input  wire logic [15:0] rdata,   // Registered read data.
	output      host_req_t   req      // Strobe, address and data.
);
	initial req = '0;
	// Write one word; the strobe stands for exactly one edge.
	task automatic wr(input logic [5:0] a, input logic [15:0] v);
		@(posedge ref_clk) req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: v};
		@(posedge ref_clk) req <= '0;
	endtask
	// Read one word; data is taken at the edge after the strobe, where it has settled.
	task automatic rd(input logic [5:0] a, output logic [15:0] v);
		@(posedge ref_clk) req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 16'h0000};
		@(posedge ref_clk) req <= '0;
		@(posedge ref_clk) v = rdata;
	endtask
endmodule

//--- bench/irq_mode_regs_tb_top.sv
// Self-checking bench for the status and mode register bank.
// Assumes the host model drives every register access.
`timescale 1ns/1ps
`define CHK(n, e, s) begin n_tests++; if ((s) !== (e)) begin miscompares++; \
	$display("MISMATCH %s expected %h seen %h", n, e, s); end end
module irq_mode_regs_tb_top import irq_mode_pkg::*;;
	logic        ref_clk = 1'b0, link_clk = 1'b0, rst = 1'b1; // Clocks and reset.
	host_req_t   req;                                          // Host strobes.
	logic [15:0] rdata, d, dstate = 16'hff64;                  // Read data, delineation.
	err_events_t ev = '0;                                      // Error pulses.
	logic [7:0]  t2 = 8'h00, fail = 8'h00, cfg = 8'h0f;        // Events, failures, roles.
	logic [7:0]  dls = 8'h00, dle = 8'h00;                     // Delineation loss events.
	logic [1:0]  filt = 2'h0;                                  // Filter queue events.
	logic        qne = 1'b0, qrd = 1'b0;                       // Queue level and read.
	logic [3:0]  lvl = 4'h1;                                   // Buffer level.
	logic        irq, below, t2_en;                            // Registered outputs.
	mode_ctl_t   mctl;                                         // Framer controls.
	int          miscompares = 0, n_tests = 0, cyc = 0;        // Counters.
	always #50 ref_clk = ~ref_clk;
	always #80 link_clk = ~link_clk;
	irq_host_model host_u (.ref_clk(ref_clk), .rdata(rdata), .req(req));
	irq_mode_regs dut_u (.ref_clk(ref_clk), .rst(rst), .link_clk(link_clk), .host_req(req),
		.host_rdata(rdata), .cell_start_strobe(1'b0), .cell_start_check_en(1'b0),
		.err_event(ev), .queue_has_entries(qne), .queue_read(qrd),
		.filter_queue_full(filt[0]), .filter_queue_nonempty(filt[1]), .timestamp_overflow(t2),
		.first_group_timer_expired(t2), .second_group_timer_expired(t2),
		.delin_loss_start(dls), .delin_loss_end(dle), .cell_port_cfg(cfg),
		.port_delineation_state(dstate), .rx_clock_fail_raw(fail), .bus_style_pin(1'b1),
		.canceller_pin_state(1'b0), .line_standard_pin_state(1'b1),
		.tx_buffer_level(lvl), .tx_buffer_below_level(below), .irq(irq),
		.second_timer_group_enable(t2_en), .mode_ctl(mctl));
	// Print the counts and the verdict, then stop.
	task automatic print_verdict();
		$display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	// Reset values, an unmapped place and the buffer level output.
	task automatic t_reset();
		host_u.rd(ADDR_MASK, d); `CHK("mask", 16'hffff, d)
		host_u.rd(ADDR_MODE, d); `CHK("mode", 16'h1100, d)
		host_u.rd(6'h20, d); `CHK("unmapped", 16'h0000, d)
		`CHK("below", 1'b1, below)
		lvl <= 4'h3; repeat (3) @(posedge ref_clk);
		`CHK("not below", 1'b0, below)
		@(posedge ref_clk) t2 <= 8'h01;
		@(posedge ref_clk) t2 <= 8'h00;
		host_u.rd(ADDR_STAT2, d); `CHK("timer2 off", 16'h0000, d)
		fork
			host_u.rd(ADDR_EXT_TIM1, d);
			begin @(posedge ref_clk) t2 <= 8'h01; @(posedge ref_clk) t2 <= 8'h00; end
		join
		`CHK("timer1 first", 16'h0001, d)
		host_u.rd(ADDR_EXT_TIM1, d); `CHK("timer1 kept", 16'h0001, d)
		host_u.rd(ADDR_EXT_TIM1, d); `CHK("timer1 clear", 16'h0000, d)
		$display("done reset");
	endtask
	// Error latch, masking and clear on read with a colliding event.
	task automatic t_errors();
		@(posedge ref_clk) ev <= 7'h01;
		@(posedge ref_clk) ev <= '0;
		repeat (2) @(posedge ref_clk);
		`CHK("masked irq", 1'b0, irq)
		host_u.wr(ADDR_MASK, 16'hfffe); repeat (2) @(posedge ref_clk);
		`CHK("irq", 1'b1, irq)
		fork
			host_u.rd(ADDR_STAT1, d);
			begin @(posedge ref_clk) ev <= 7'h01; @(posedge ref_clk) ev <= '0; end
		join
		`CHK("status", 16'h0001, d)
		host_u.rd(ADDR_STAT1, d); `CHK("kept", 16'h0001, d)
		host_u.rd(ADDR_STAT1, d); `CHK("cleared", 16'h0000, d)
		$display("done errors");
	endtask
	// Summary bits follow the underlying registers.
	task automatic t_summary();
		host_u.wr(ADDR_TIMER_EN, 16'h0001); repeat (2) @(posedge ref_clk);
		`CHK("timer run", 1'b1, t2_en)
		// Ports 0 to 3 are cell ports, port 4 an adaptation port.
		@(posedge ref_clk) begin
			t2 <= 8'h11;
			filt <= 2'h3;
			dls <= 8'h01;
			dle <= 8'h12;
			qne <= 1'b1;
		end
		@(posedge ref_clk) begin
			t2 <= 8'h00;
			filt <= 2'h0;
			dls <= 8'h00;
			dle <= 8'h00;
			qne <= 1'b0;
		end
		host_u.rd(ADDR_STAT1, d); `CHK("sum", 16'hfc00, d & 16'hfc00)
		host_u.rd(ADDR_STAT2, d); `CHK("timer2", 16'h0011, d)
		host_u.rd(ADDR_EXT_TIM1, d); `CHK("timer1", 16'h0011, d)
		host_u.rd(ADDR_STAT1, d); `CHK("sum left", 16'hd800, d & 16'hfc00)
		host_u.rd(ADDR_EXT_TS, d); `CHK("stamp", 16'h0010, d)
		host_u.rd(ADDR_EXT_FILT, d); `CHK("filter", 16'h0003, d)
		host_u.rd(ADDR_EXT_DELIN, d); `CHK("loss", 16'h0201, d)
		@(posedge ref_clk) qrd <= 1'b1;
		@(posedge ref_clk) qrd <= 1'b0;
		host_u.rd(ADDR_STAT1, d); `CHK("sum gone", 16'h0000, d)
		$display("done summary");
	endtask
	// Live status words and straps.
	task automatic t_status();
		host_u.rd(ADDR_REV, d); `CHK("rev", {7'h00, 3'h5, REVISION}, d)
		host_u.rd(ADDR_DELIN, d); `CHK("delin", 16'h0064, d)
		fail <= 8'h05; repeat (4) @(posedge ref_clk);
		host_u.rd(ADDR_CLKMON, d); `CHK("fail", 16'h0005, d)
		fail <= 8'h00; repeat (4) @(posedge ref_clk);
		host_u.rd(ADDR_CLKMON, d); `CHK("back", 16'h0000, d)
		$display("done status");
	endtask
	// Every framer mode, mode written before the clock source.
	task automatic t_mode();
		for (int m = 0; m < 4; m++) begin
			host_u.wr(ADDR_MODE, 16'h1100 | 16'(m << 1)); repeat (2) @(posedge ref_clk);
			`CHK("om", framer_mode_t'(m), mctl.mode)
		end
		host_u.wr(ADDR_MODE, 16'h1102); host_u.wr(ADDR_TXCLK, 16'hd8e4);
		host_u.rd(ADDR_TXCLK, d); `CHK("txclk", 16'hd8e4, d)
		`CHK("txsrc", 16'hd8e4, mctl.tx_clock_source)
		host_u.wr(ADDR_MODE, 16'h110e); repeat (2) @(posedge ref_clk);
		`CHK("sync2 edges", 2'b01, {mctl.tx_drive_rise, mctl.rx_sample_rise})
		`CHK("sync src", 16'h0000, mctl.tx_clock_source)
		$display("done mode");
	endtask
	// Hang guard.
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 4000) begin
			miscompares++;
			print_verdict();
		end
	end
	// Main sequence.
	initial begin
		repeat (4) @(posedge ref_clk);
		rst <= 1'b0;
		repeat (2) @(posedge ref_clk);
		t_reset();
		t_errors();
		t_summary();
		t_status();
		t_mode();
		print_verdict();
	end
endmodule
